// >>> shared/mcpin_map.svh
// constants for the mode and parameter input loader
`ifndef MCPIN_MAP_SVH
`define MCPIN_MAP_SVH

`define MCPIN_CLK_HZ          20000000
`define MCPIN_DEBOUNCE_MS     10
`define MCPIN_DEBOUNCE_CYC    ((`MCPIN_CLK_HZ / 1000) * `MCPIN_DEBOUNCE_MS)
`define MCPIN_SETTLE_US       20
`define MCPIN_SETTLE_CYC      ((`MCPIN_CLK_HZ / 1000000) * `MCPIN_SETTLE_US)
`define MCPIN_GAP_CYC         4
`define MCPIN_NUM_SEL         6
`define MCPIN_SEL_RETRY       0
`define MCPIN_SEL_DEADTIME    1
`define MCPIN_SEL_BOOST       2
`define MCPIN_SEL_PWMFREQ     3
`define MCPIN_SEL_SPEED       4
`define MCPIN_SEL_ACCEL       5
`define MCPIN_FIRST_LIVE_SEL  3
`define MCPIN_ADC_W           10
`define MCPIN_RETRY_MIN_S     1
`define MCPIN_RETRY_MAX_S     60
`define MCPIN_RETRY_S_PER_V   12

`endif

// >>> shared/mcpin_pkg.sv
// types for the mode and parameter input loader
package mcpin_pkg;

    typedef enum logic [2:0] {
        MCPIN_ST_INIT   = 3'b000,
        MCPIN_ST_GAP    = 3'b001,
        MCPIN_ST_SETTLE = 3'b010,
        MCPIN_ST_SAMPLE = 3'b011,
        MCPIN_ST_HOSTED = 3'b100
    } mcpin_state_t;

    typedef struct packed {
        logic [9:0] retry;
        logic [9:0] deadtime;
        logic [9:0] boost;
        logic [9:0] pwmfreq;
        logic [9:0] speed;
        logic [9:0] accel;
    } mcpin_params_t;

    typedef struct packed {
        logic start_cmd;
        logic dir_fwd;
        logic start_level;
        logic dir_level;
    } mcpin_switch_t;

endpackage

// >>> rtl/mcpin_sync.sv
// three-stage synchroniser with optional debounce filter
`timescale 1ns/1ps
`default_nettype none
module mcpin_sync #(
    parameter int HOLD_CYC = 1,
    parameter bit RST_VAL  = 1'b0
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // pin and filtered level
    input  wire logic pin_in,
    output logic      level_q
);
    localparam int CW = $clog2(HOLD_CYC + 1);

    logic [2:0]    sync_q;
    logic [CW-1:0] cnt_q;
    wire           agree    = (sync_q[1] == sync_q[2]);
    wire           differs  = agree && (sync_q[2] != level_q);
    wire           hold_end = (cnt_q >= CW'(HOLD_CYC - 1));

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sync_q  <= {3{RST_VAL}};
            cnt_q   <= '0;
            level_q <= RST_VAL;
        end else begin
            sync_q <= {sync_q[1:0], pin_in};
            if (!differs) begin
                cnt_q <= '0;
            end else if (hold_end) begin
                cnt_q   <= '0;
                level_q <= sync_q[2];
            end else begin
                cnt_q <= cnt_q + CW'(1);
            end
        end
    end
endmodule // mcpin_sync
`default_nettype wire

// >>> rtl/mcpin_start_guard.sv
// start command that needs a high level before a low counts
`timescale 1ns/1ps
`default_nettype none
module mcpin_start_guard (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // debounced level and command
    input  wire logic level,
    input  wire logic enable,
    output logic      start_q
);
    logic armed_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            armed_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            if (level) begin
                armed_q <= 1'b1;
            end
            start_q <= enable && armed_q && !level;
        end
    end

    start_armed_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        start_q |-> $past(armed_q) && !$past(level))
        else $error("start issued without prior high level");
endmodule // mcpin_start_guard
`default_nettype wire

// >>> rtl/mcpin_loader.sv
// mode select, switch debounce and standalone parameter scan
// ****************************************************************
// Overview of operation
// - pwm outputs float while supply is low
// - mode pin high at init selects standalone
// - standalone drives selects and watches inputs
// - select low, then sample shared analog input
// - start switch debounced inside
// - start low counts only after high
// - direction switch debounced, level sensitive
// - live parameters rescanned continuously
// - startup parameters read at reset
// - hosted mode takes setup from host only
// - mode pin low at init selects hosted
// - retry time scaled twelve seconds per volt
// - hosted mode ignores pins, still monitors them
// ****************************************************************
`timescale 1ns/1ps
`default_nettype none
`include "mcpin_map.svh"
module mcpin_loader import mcpin_pkg::*; #(
    parameter int DEBOUNCE_CYC = `MCPIN_DEBOUNCE_CYC,
    parameter int SETTLE_CYC   = `MCPIN_SETTLE_CYC,
    parameter int NUM_SEL      = `MCPIN_NUM_SEL,
    parameter int ADC_W        = `MCPIN_ADC_W
) (
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               sys_rst,
    // supply monitor
    input  wire logic               supply_ok,
    // mode and switch pins
    input  wire logic               boost_and_mode_select_pin,
    input  wire logic               start_switch_input,
    input  wire logic               direction_switch_input,
    input  wire logic               polarity_basefreq_jumper_input,
    // parameter select pins, open drain style
    output logic [NUM_SEL-1:0]      param_sel_out,
    output logic [NUM_SEL-1:0]      param_sel_oe,
    // analog converter on the shared input
    output logic                    adc_convert,
    input  wire logic               adc_done,
    input  wire logic [ADC_W-1:0]   adc_value,
    // host configuration path
    input  wire logic               host_wr,
    input  wire mcpin_params_t      host_params,
    input  wire logic               host_start,
    input  wire logic               host_fwd,
    // pwm pad control from the core
    input  wire logic [5:0]         pwm_core_out,
    output logic [5:0]              pwm_pad_out,
    output logic [5:0]              pwm_pad_oe,
    // results
    output logic                    mode_standalone_q,
    output logic                    mode_valid_q,
    output logic                    init_done_q,
    output mcpin_params_t           params_q,
    output logic [5:0]              retry_secs_q,
    output mcpin_switch_t           switch_q,
    output logic                    run_start_q,
    output logic                    run_fwd_q
);
    // ****************************************************************
    // supply gate on pwm pads
    // ****************************************************************
    logic supply_lvl;

    mcpin_sync #(.HOLD_CYC(1), .RST_VAL(1'b0)) u_supply (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .pin_in  (supply_ok),
        .level_q (supply_lvl)
    );

    assign pwm_pad_oe  = {6{supply_lvl && supply_ok}};
    assign pwm_pad_out = pwm_core_out;

    // ****************************************************************
    // pin synchronisers and debounce
    // ****************************************************************
    logic mode_lvl;
    logic start_lvl;
    logic dir_lvl;
    logic start_cmd;

    mcpin_sync #(.HOLD_CYC(1), .RST_VAL(1'b0)) u_mode (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .pin_in  (boost_and_mode_select_pin),
        .level_q (mode_lvl)
    );

    mcpin_sync #(.HOLD_CYC(DEBOUNCE_CYC), .RST_VAL(1'b0)) u_start (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .pin_in  (start_switch_input),
        .level_q (start_lvl)
    );

    mcpin_sync #(.HOLD_CYC(DEBOUNCE_CYC), .RST_VAL(1'b0)) u_dir (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .pin_in  (direction_switch_input),
        .level_q (dir_lvl)
    );

    mcpin_start_guard u_guard (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .level   (start_lvl),
        .enable  (mode_standalone_q),
        .start_q (start_cmd)
    );

    // ****************************************************************
    // mode latch and scan sequencer
    // ****************************************************************
    localparam int SCW = $clog2(SETTLE_CYC + `MCPIN_GAP_CYC + 1);
    localparam int IXW = $clog2(NUM_SEL);

    mcpin_state_t   state_q;
    mcpin_state_t   state_d;
    logic [SCW-1:0] wait_q;
    logic [IXW-1:0] idx_q;
    logic [2:0]     boot_q;
    logic [NUM_SEL*ADC_W-1:0] scan_q;

    wire boot_ready = (boot_q == 3'h4);
    wire wait_done  = (wait_q == '0);
    wire last_sel   = (idx_q == IXW'(NUM_SEL - 1));
    wire [IXW-1:0] next_idx = last_sel ? IXW'(`MCPIN_FIRST_LIVE_SEL) : idx_q + IXW'(1);

    always_comb begin
        state_d = state_q;
        case (state_q)
            MCPIN_ST_INIT: begin
                if (boot_ready) begin
                    state_d = mode_lvl ? MCPIN_ST_GAP : MCPIN_ST_HOSTED;
                end
            end
            MCPIN_ST_GAP: begin
                if (wait_done) begin
                    state_d = MCPIN_ST_SETTLE;
                end
            end
            MCPIN_ST_SETTLE: begin
                if (wait_done) begin
                    state_d = MCPIN_ST_SAMPLE;
                end
            end
            MCPIN_ST_SAMPLE: begin
                if (adc_done) begin
                    state_d = MCPIN_ST_GAP;
                end
            end
            MCPIN_ST_HOSTED: state_d = MCPIN_ST_HOSTED;
            default:         state_d = MCPIN_ST_INIT;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            boot_q <= 3'h0;
        end else if (!boot_ready) begin
            boot_q <= boot_q + 3'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            mode_standalone_q <= 1'b0;
            mode_valid_q      <= 1'b0;
        end else if (state_q == MCPIN_ST_INIT && boot_ready) begin
            mode_standalone_q <= mode_lvl;
            mode_valid_q      <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q     <= MCPIN_ST_INIT;
            wait_q      <= SCW'(`MCPIN_GAP_CYC);
            idx_q       <= '0;
            init_done_q <= 1'b0;
            scan_q      <= '0;
        end else begin
            state_q <= state_d;
            if (state_q != state_d) begin
                wait_q <= (state_d == MCPIN_ST_SETTLE) ? SCW'(SETTLE_CYC)
                                                       : SCW'(`MCPIN_GAP_CYC);
            end else if (!wait_done) begin
                wait_q <= wait_q - SCW'(1);
            end
            if (state_q == MCPIN_ST_SAMPLE && adc_done) begin
                scan_q[idx_q*ADC_W +: ADC_W] <= adc_value;
                idx_q <= next_idx;
                if (last_sel) begin
                    init_done_q <= 1'b1;
                end
            end
            if (state_q == MCPIN_ST_INIT && boot_ready && !mode_lvl) begin
                init_done_q <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // select pin drive
    // ****************************************************************
    wire sel_active = (state_q == MCPIN_ST_SETTLE) || (state_q == MCPIN_ST_SAMPLE);
    // scan slot 0 lands in the top field of the parameter struct
    wire [NUM_SEL*ADC_W-1:0] scan_order;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SEL; gi++) begin : g_sel
            assign param_sel_oe[gi]  = sel_active && (idx_q == IXW'(gi));
            assign param_sel_out[gi] = 1'b0;
            assign scan_order[(NUM_SEL-1-gi)*ADC_W +: ADC_W] = scan_q[gi*ADC_W +: ADC_W];
        end
    endgenerate

    assign adc_convert = (state_q == MCPIN_ST_SAMPLE);

    // ****************************************************************
    // parameter and control outputs
    // ****************************************************************
    wire  [ADC_W-1:0] retry_raw = scan_q[`MCPIN_SEL_RETRY*ADC_W +: ADC_W];
    // full scale is five volts: seconds = code * 60 / full code
    wire  [ADC_W+5:0] retry_mul = (ADC_W+6)'(retry_raw) * (ADC_W+6)'(`MCPIN_RETRY_S_PER_V * 5);
    wire  [5:0]       retry_scl = 6'(retry_mul >> ADC_W);
    wire  [5:0]       retry_cl  = (retry_scl < 6'(`MCPIN_RETRY_MIN_S)) ? 6'(`MCPIN_RETRY_MIN_S)
                                : retry_scl;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            params_q     <= '0;
            retry_secs_q <= 6'(`MCPIN_RETRY_MIN_S);
            switch_q     <= '0;
            run_start_q  <= 1'b0;
            run_fwd_q    <= 1'b0;
        end else begin
            switch_q <= '{start_cmd: start_cmd, dir_fwd: dir_lvl,
                          start_level: start_lvl, dir_level: dir_lvl};
            if (mode_valid_q && !mode_standalone_q) begin
                if (host_wr) begin
                    params_q <= host_params;
                end
                run_start_q <= host_start;
                run_fwd_q   <= host_fwd;
            end else if (mode_valid_q) begin
                params_q     <= mcpin_params_t'(scan_order);
                retry_secs_q <= retry_cl;
                run_start_q  <= start_cmd;
                run_fwd_q    <= dir_lvl;
            end
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    // select exclusivity
    one_select_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $onehot0(param_sel_oe))
        else $error("more than one select line driven");

    sample_under_sel_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        adc_convert |-> param_sel_oe[idx_q] && !param_sel_out[idx_q])
        else $error("conversion without select low");

    mode_held_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $past(mode_valid_q) |-> $stable(mode_standalone_q))
        else $error("mode changed after init");

    supply_float_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !supply_ok |-> pwm_pad_oe == 6'h00)
        else $error("pwm pads driven on low supply");

    hosted_ignore_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (mode_valid_q && !mode_standalone_q) ##1 1'b1 |-> run_start_q == $past(host_start))
        else $error("hosted start not from host");

    hosted_quiet_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (mode_valid_q && !mode_standalone_q) |-> param_sel_oe == '0)
        else $error("select driven in hosted mode");

    mode_pick_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_q == MCPIN_ST_INIT && boot_ready) |=> mode_standalone_q == $past(mode_lvl))
        else $error("mode not taken from pin");

    retry_range_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        retry_secs_q >= 6'h01 && retry_secs_q <= 6'h3C)
        else $error("retry seconds out of range");
endmodule // mcpin_loader
`default_nettype wire

// >>> verification/mcpin_mux_model.sv
// external analog mux and converter seen through the shared parameter input
`timescale 1ns/1ps
`default_nettype none
module mcpin_mux_model import mcpin_pkg::*; (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    // select lines from the loader
    input  wire logic [5:0]       param_sel_out,
    input  wire logic [5:0]       param_sel_oe,
    // converter handshake
    input  wire logic             adc_convert,
    output logic                  adc_done,
    output logic [9:0]            adc_value,
    // bench control
    input  wire logic             slow,
    input  wire logic [5:0][9:0]  chan_val,
    output logic                  sel_fault_q
);
    logic [3:0] cnt_q;
    logic [9:0] val_q;
    logic [9:0] mux_val;
    logic       one_sel;
    logic       bad_sel;
    // ****************************************************************
    // mux and pull-up
    // ****************************************************************
    assign one_sel   = ($countones(param_sel_oe) == 1);
    assign bad_sel   = ($countones(param_sel_oe) > 1) || (adc_convert && !one_sel)
                       || ((param_sel_oe & param_sel_out) != 6'h00);
    always_comb begin
        mux_val = 10'h3FF;
        for (int i = 0; i < 6; i++) begin
            if (one_sel && param_sel_oe[i]) begin
                mux_val = chan_val[i];
            end
        end
    end
    // value only stands in the done cycle, otherwise it shows garbage
    assign adc_value = adc_done ? val_q : ~val_q;
    // ****************************************************************
    // converter timing, prompt or slow
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cnt_q       <= 4'h0;
            adc_done    <= 1'b0;
            val_q       <= 10'h000;
            sel_fault_q <= 1'b0;
        end else begin
            if (bad_sel) begin
                sel_fault_q <= 1'b1;
            end
            if (adc_done) begin
                adc_done <= 1'b0;
                cnt_q    <= 4'h0;
            end else if (adc_convert) begin
                if (cnt_q == (slow ? 4'h6 : 4'h0)) begin
                    adc_done <= 1'b1;
                    val_q    <= mux_val;
                end else begin
                    cnt_q <= cnt_q + 4'h1;
                end
            end
        end
    end
endmodule // mcpin_mux_model
`default_nettype wire

// >>> verification/test_mcpin_loader.sv
// self-checking bench for the mode and parameter input loader
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
`define WAIT(c) begin wait_n = 0; while (!(c) && wait_n < 3000) begin \
    @(posedge clk_sys); #1; wait_n++; end if (!(c)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h expected %h", $time, 1'b0, 1'b1); end_sim; end end
module test_mcpin_loader import mcpin_pkg::*;;
    logic            clk_sys, sys_rst, supply_ok, mode_pin, start_pin, dir_pin, jumper;
    logic [5:0]      sel_out, sel_oe, pwm_core_out, pwm_pad_out, pwm_pad_oe;
    logic            adc_convert, adc_done, host_wr, host_start, host_fwd, slow;
    logic [9:0]      adc_value;
    mcpin_params_t   host_params, params_q, hp;
    logic            mode_standalone_q, mode_valid_q, init_done_q, run_start_q, run_fwd_q;
    logic [5:0]      retry_secs_q;
    mcpin_switch_t   switch_q;
    logic [5:0][9:0] chan_val;
    logic            sel_fault_q;
    int              n_mismatch, checks_done, wait_n;

    mcpin_loader #(.DEBOUNCE_CYC(8), .SETTLE_CYC(4)) u_dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .supply_ok(supply_ok),
        .boost_and_mode_select_pin(mode_pin), .start_switch_input(start_pin),
        .direction_switch_input(dir_pin), .polarity_basefreq_jumper_input(jumper),
        .param_sel_out(sel_out), .param_sel_oe(sel_oe), .adc_convert(adc_convert),
        .adc_done(adc_done), .adc_value(adc_value), .host_wr(host_wr),
        .host_params(host_params), .host_start(host_start), .host_fwd(host_fwd),
        .pwm_core_out(pwm_core_out), .pwm_pad_out(pwm_pad_out), .pwm_pad_oe(pwm_pad_oe),
        .mode_standalone_q(mode_standalone_q), .mode_valid_q(mode_valid_q),
        .init_done_q(init_done_q), .params_q(params_q), .retry_secs_q(retry_secs_q),
        .switch_q(switch_q), .run_start_q(run_start_q), .run_fwd_q(run_fwd_q));

    mcpin_mux_model u_mux (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .param_sel_out(sel_out),
        .param_sel_oe(sel_oe), .adc_convert(adc_convert), .adc_done(adc_done),
        .adc_value(adc_value), .slow(slow), .chan_val(chan_val), .sel_fault_q(sel_fault_q));

    always #25 clk_sys = ~clk_sys;

    function automatic mcpin_params_t exp_params();
        return {chan_val[0], chan_val[1], chan_val[2], chan_val[3], chan_val[4], chan_val[5]};
    endfunction

    function automatic logic [5:0] exp_retry(input logic [9:0] code);
        logic [15:0] p;
        p = ({6'h00, code} * 16'h003C) >> 10;
        return (p < 16'h0001) ? 6'h01 : p[5:0];
    endfunction

    task automatic end_sim();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // reset with the strap and start switch set, then wait for the mode decision
    task automatic boot(input logic mode, input logic st);
        @(posedge clk_sys);
        sys_rst   <= 1'b1;
        mode_pin  <= mode;
        start_pin <= st;
        repeat (10) @(posedge clk_sys);
        #1;
        `CHK({retry_secs_q, mode_valid_q, sel_oe}, {6'h01, 1'b0, 6'h00})
        `CHK(pwm_pad_oe, 6'h00)
        @(posedge clk_sys);
        sys_rst <= 1'b0;
        `WAIT(mode_valid_q === 1'b1)
        `CHK(mode_standalone_q, mode)
    endtask

    task automatic sc_standalone();
        chan_val = {10'h155, 10'h2AA, 10'h0F0, 10'h301, 10'h040, 10'h222};
        boot(1'b1, 1'b1);
        `WAIT(init_done_q === 1'b1)
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK(params_q, exp_params())
        `CHK(retry_secs_q, exp_retry(chan_val[0]))
    endtask

    task automatic sc_live();
        mcpin_params_t old;
        old = params_q;
        slow <= 1'b1;
        mode_pin <= 1'b0;
        chan_val = {10'h3C3, 10'h011, 10'h1E0, 10'h0AB, 10'h3FE, 10'h001};
        hp = 60'h0123456789ABCDE;
        @(posedge clk_sys);
        host_wr <= 1'b1;
        host_params <= hp;
        @(posedge clk_sys);
        host_wr <= 1'b0;
        `WAIT(params_q.speed === 10'h011 && params_q.accel === 10'h3C3)
        `WAIT(params_q.pwmfreq === 10'h1E0)
        `CHK({params_q.pwmfreq, params_q.speed, params_q.accel}, {10'h1E0, 10'h011, 10'h3C3})
        `CHK({params_q.retry, params_q.deadtime, params_q.boost}, {old.retry, old.deadtime, old.boost})
        `CHK(retry_secs_q, exp_retry(old.retry))
        `CHK(mode_standalone_q, 1'b1)
        `CHK(params_q === hp, 1'b0)
        `CHK(sel_fault_q, 1'b0)
        slow <= 1'b0;
    endtask

    task automatic sc_start_guard();
        chan_val[0] = 10'h000;
        boot(1'b1, 1'b0);
        `WAIT(init_done_q === 1'b1)
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK(retry_secs_q, 6'h01)
        repeat (40) @(posedge clk_sys);
        #1;
        `CHK(run_start_q, 1'b0)
        start_pin <= 1'b1;
        `WAIT(switch_q.start_level === 1'b1)
        @(posedge clk_sys);
        start_pin <= 1'b0;
        repeat (3) @(posedge clk_sys);
        start_pin <= 1'b1;
        repeat (30) @(posedge clk_sys);
        #1;
        `CHK(run_start_q, 1'b0)
        start_pin <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        `CHK(run_start_q, 1'b0)
        `WAIT(run_start_q === 1'b1)
        `CHK(switch_q.start_cmd, 1'b1)
        `CHK(sel_fault_q, 1'b0)
    endtask

    task automatic sc_direction();
        `WAIT(run_fwd_q === 1'b1)
        dir_pin <= 1'b0;
        repeat (3) @(posedge clk_sys);
        dir_pin <= 1'b1;
        repeat (30) @(posedge clk_sys);
        #1;
        `CHK(run_fwd_q, 1'b1)
        dir_pin <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        `CHK(run_fwd_q, 1'b1)
        `WAIT(run_fwd_q === 1'b0)
        `CHK(switch_q.dir_level, 1'b0)
        `CHK(switch_q.dir_fwd, 1'b0)
    endtask

    task automatic sc_hosted();
        host_start <= 1'b0;
        host_fwd   <= 1'b1;
        boot(1'b0, 1'b1);
        mode_pin <= 1'b1;
        for (int i = 0; i < 60; i++) begin
            @(posedge clk_sys);
            #1;
            `CHK({sel_oe, adc_convert}, 7'h00)
        end
        `CHK(mode_standalone_q, 1'b0)
        hp = 60'hFEDCBA987654321;
        host_wr <= 1'b1;
        host_params <= hp;
        @(posedge clk_sys);
        host_wr <= 1'b0;
        `WAIT(params_q === hp)
        `WAIT(run_fwd_q === 1'b1)
        dir_pin   <= 1'b0;
        start_pin <= 1'b0;
        repeat (30) @(posedge clk_sys);
        #1;
        `CHK({run_start_q, run_fwd_q}, 2'b01)
        `CHK({switch_q.start_level, switch_q.dir_level}, 2'b00)
        `CHK(switch_q.start_cmd, 1'b0)
        host_start <= 1'b1;
        host_fwd   <= 1'b0;
        `WAIT(run_start_q === 1'b1 && run_fwd_q === 1'b0)
    endtask

    task automatic sc_supply();
        pwm_core_out <= 6'h2A;
        supply_ok    <= 1'b0;
        @(posedge clk_sys);
        #1;
        `CHK(pwm_pad_oe, 6'h00)
        supply_ok <= 1'b1;
        `WAIT(pwm_pad_oe === 6'h3F)
        `CHK(pwm_pad_out, 6'h2A)
    endtask

    initial begin
        #4000000;
        n_mismatch++;
        end_sim();
    end

    initial begin
        clk_sys = 1'b0;
        sys_rst = 1'b1;
        supply_ok = 1'b1;
        mode_pin = 1'b1;
        start_pin = 1'b1;
        dir_pin = 1'b1;
        jumper = 1'b0;
        host_wr = 1'b0;
        host_params = '0;
        host_start = 1'b0;
        host_fwd = 1'b0;
        pwm_core_out = 6'h15;
        slow = 1'b0;
        chan_val = '0;
        n_mismatch = 0;
        checks_done = 0;
        sc_standalone();
        sc_live();
        sc_start_guard();
        sc_direction();
        jumper <= 1'b1;
        sc_supply();
        sc_hosted();
        end_sim();
    end
endmodule // test_mcpin_loader
`default_nettype wire
